// File: rtl/dbs_sram_if.sv
// Purpose: device-side logic of a common-i/o ddr sram, burst of two
// Assumes: k, k-bar and every other pin are sampled by clk, which runs
//          much faster than k; all pins pass two flip-flops first
// Notes:   one k period is one command slot; beats follow k and k-bar
//
// Notes on behaviour
// - load_n high at k rise blocks capture; pipeline drains to deselect.
// - address, load_n and rw_sel are sampled only on k rising edges.
// - load_n low with rw_sel high at k rise captures a read.
// - second write beat is captured on the following k-bar rise.
// - every accepted command moves exactly two beats, k then k-bar.
// - a new command may be loaded every k cycle, or less often.
// - deselects travel the read pipeline; read beats finish first.
// - byte enables are sampled with each write beat, per beat.
// - a high byte enable leaves that 9-bit byte of memory unchanged.
// - any byte mask in either beat; two beats per address.
// - free-running cycle counter periodically starts impedance check.
// - each check moves the drive code by at most one step.
// - drive setting is a binary-weighted code of impedance steps.
// - termination off when its enable pin is low, on when high.
// - with termination on, clock and byte-enable termination stay on.
// - data termination drops half a cycle around driven read data.
// - pll is disabled while pll_disable_n is low.
// - nop or write: data drivers off for one cycle, two cycles later.
// - byte enable n covers data bits 9n to 9n+8.
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"

module dbs_sram_if #(
  parameter int DATA_W     = `DBS_DATA_W,
  parameter int ADDR_W     = `DBS_ADDR_W,
  parameter int IMP_W      = `DBS_IMP_W,
  parameter int CAL_PERIOD = `DBS_CAL_PERIOD
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  clk_en,
  input  wire logic                                  k_in,
  input  wire logic                                  k_bar_in,
  input  wire logic                                  load_n,
  input  wire logic                                  rw_sel,
  input  wire logic [ADDR_W-1:0]                     sync_addr_in,
  input  wire logic [DATA_W/`DBS_BYTE_W-1:0]         byte_write_enable_n,
  input  wire logic [DATA_W-1:0]                     dq_in,
  output var  logic [DATA_W-1:0]                     dq_out,
  output var  logic                                  dq_oe,
  output var  logic                                  echo_clock,
  output var  logic                                  echo_clock_n,
  output var  logic                                  read_valid_out,
  input  wire logic                                  termination_enable,
  output var  logic                                  term_dq_on,
  output var  logic                                  term_ctl_on,
  input  wire logic                                  pll_disable_n,
  output var  logic                                  pll_on,
  input  wire logic                                  imp_above,
  input  wire logic                                  imp_below,
  output var  logic [IMP_W-1:0]                      drive_code
);

  localparam int BW    = `DBS_BYTE_W;
  localparam int BYTES = DATA_W / BW;
  localparam int AD_LO = DATA_W + BYTES;
  localparam int FL_LO = AD_LO + ADDR_W;
  localparam int PW    = FL_LO + `DBS_F_COUNT;
  localparam int CW    = (CAL_PERIOD > 2) ? $clog2(CAL_PERIOD) : 1;
  localparam int WW    = 2 * DATA_W;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam logic [CW-1:0]    CAL_LAST = CW'(CAL_PERIOD - 1);
  localparam logic [IMP_W-1:0] IMP_RST  = IMP_W'(1 << (IMP_W - 1));
  localparam logic [IMP_W-1:0] IMP_MAX  = {IMP_W{1'b1}};

  // parameters the logic cannot serve
  generate
    if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 1 ||
        ADDR_W > `DBS_ADDR_MAX || IMP_W < 2 || CAL_PERIOD < 2) begin : g_bad
      $error("dbs_sram_if: unsupported parameter values");
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin synchronisers: every pin passes two flip-flops
  // ---------------------------------------------------------------
  wire logic [PW-1:0] pin_raw;
  logic      [PW-1:0] pin_meta;
  logic      [PW-1:0] pin_sync;

  assign pin_raw = {k_in, k_bar_in, load_n, rw_sel, termination_enable,
                    pll_disable_n, imp_above, imp_below,
                    sync_addr_in, byte_write_enable_n, dq_in};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire logic              k_s;
  wire logic              kb_s;
  wire logic              ld_n_s;
  wire logic              rw_s;
  wire logic              te_s;
  wire logic              pll_dis_n_s;
  wire logic              above_s;
  wire logic              below_s;
  wire logic [ADDR_W-1:0] addr_s;
  wire logic [BYTES-1:0]  bwn_s;
  wire logic [DATA_W-1:0] dq_s;

  assign k_s         = pin_sync[FL_LO + `DBS_F_K];
  assign kb_s        = pin_sync[FL_LO + `DBS_F_KB];
  assign ld_n_s      = pin_sync[FL_LO + `DBS_F_LOAD_N];
  assign rw_s        = pin_sync[FL_LO + `DBS_F_RW];
  assign te_s        = pin_sync[FL_LO + `DBS_F_TERM_EN];
  assign pll_dis_n_s = pin_sync[FL_LO + `DBS_F_PLL_DIS_N];
  assign above_s     = pin_sync[FL_LO + `DBS_F_IMP_ABOVE];
  assign below_s     = pin_sync[FL_LO + `DBS_F_IMP_BELOW];
  assign addr_s      = pin_sync[AD_LO +: ADDR_W];
  assign bwn_s       = pin_sync[DATA_W +: BYTES];
  assign dq_s        = pin_sync[`DBS_BEAT0_LO +: DATA_W];

  // ---------------------------------------------------------------
  // k and k-bar rising edges, seen on the synchronised copies
  // ---------------------------------------------------------------
  logic k_prev;
  logic kb_prev;
  logic [2:0] warm;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      k_prev  <= 1'b0;
      kb_prev <= 1'b0;
      warm    <= '0;
    end else if (clk_en) begin
      k_prev  <= k_s;
      kb_prev <= kb_s;
      warm    <= {warm[1:0], 1'b1};
    end
  end

  wire logic k_rise;
  wire logic kb_rise;

  // no edge until sync flops and history hold real samples, not reset zeros
  assign k_rise  = warm[2] & k_s & ~k_prev;
  assign kb_rise = warm[2] & kb_s & ~kb_prev;

  // ---------------------------------------------------------------
  // command decode and two-slot command pipeline
  // ---------------------------------------------------------------
  wire dbs_pkg::dbs_cmd_t  next_cmd;
  wire dbs_pkg::dbs_slot_t next_slot;
  dbs_pkg::dbs_slot_t      slot1;
  dbs_pkg::dbs_slot_t      slot2;

  // load_n high means deselect; reads and writes need load_n low
  assign next_cmd = ld_n_s ? dbs_pkg::DBS_NOP :
                    (rw_s ? dbs_pkg::DBS_READ :
                            dbs_pkg::DBS_WRITE);
  assign next_slot = '{cmd: next_cmd, addr: `DBS_ADDR_MAX'(addr_s)};

  // one slot per k period; deselects ride the same depth as reads
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot1 <= '{cmd: dbs_pkg::DBS_NOP, addr: '0};
      slot2 <= '{cmd: dbs_pkg::DBS_NOP, addr: '0};
    end else if (clk_en && k_rise) begin
      slot1 <= next_slot;
      slot2 <= slot1;
    end
  end

  wire logic s1_write;
  wire logic s2_read;

  assign s1_write = (slot1.cmd == dbs_pkg::DBS_WRITE);
  assign s2_read  = (slot2.cmd == dbs_pkg::DBS_READ);

  // ---------------------------------------------------------------
  // late write: beat one on the next k rise, beat two on k-bar
  // ---------------------------------------------------------------
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_d0;
  logic [BYTES-1:0]  wr_m0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_d0   <= '0;
      wr_m0   <= '1;
    end else if (clk_en) begin
      if (k_rise) begin
        wr_pend <= s1_write;
        wr_addr <= slot1.addr[ADDR_W-1:0];
        wr_d0   <= dq_s;
        wr_m0   <= bwn_s;
      end else if (kb_rise) begin
        wr_pend <= 1'b0;
      end
    end
  end

  // array holds both beats of one address side by side
  logic [WW-1:0]     mem [DEPTH];
  wire  logic [WW-1:0] wr_old;
  wire  logic [WW-1:0] wr_merged;

  assign wr_old = mem[wr_addr];

  // per byte: keep the stored byte where its enable is high
  genvar gi;
  generate
    for (gi = 0; gi < BYTES; gi++) begin : g_byte
      assign wr_merged[gi*BW +: BW] =
        (wr_m0[gi] != `DBS_NO_MASK) ? wr_old[gi*BW +: BW]
                                    : wr_d0[gi*BW +: BW];
      assign wr_merged[DATA_W + gi*BW +: BW] =
        (bwn_s[gi] != `DBS_NO_MASK) ? wr_old[DATA_W + gi*BW +: BW]
                                    : dq_s[gi*BW +: BW];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (clk_en && kb_rise && wr_pend) begin
      mem[wr_addr] <= wr_merged;
    end
  end

  // ---------------------------------------------------------------
  // read output: beat one on k rise two slots on, beat two on k-bar
  // ---------------------------------------------------------------
  wire  logic [WW-1:0]     rd_word;
  logic [DATA_W-1:0]       rd_hi;
  dbs_pkg::dbs_rdstat_t    rd_stat;

  assign rd_word = mem[slot2.addr[ADDR_W-1:0]];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_stat <= '{oe: 1'b0, valid: 1'b0};
      rd_hi   <= '0;
      dq_out  <= '0;
    end else if (clk_en) begin
      if (k_rise) begin
        // nop and write slots release the drivers for one cycle
        rd_stat <= '{oe: s2_read, valid: s2_read};
        rd_hi   <= rd_word[DATA_W +: DATA_W];
        dq_out  <= s2_read ? rd_word[0 +: DATA_W] : '0;
      end else if (kb_rise && rd_stat.oe) begin
        dq_out  <= rd_hi;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_oe          <= 1'b0;
      read_valid_out <= 1'b0;
    end else if (clk_en && k_rise) begin
      dq_oe          <= s2_read;
      read_valid_out <= s2_read;
    end
  end

  // echo clocks follow k and k-bar so valid lines up with them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      echo_clock   <= `DBS_ECHO_RST;
      echo_clock_n <= ~`DBS_ECHO_RST;
    end else if (clk_en) begin
      if (k_rise) begin
        echo_clock   <= 1'b1;
        echo_clock_n <= 1'b0;
      end else if (kb_rise) begin
        echo_clock   <= 1'b0;
        echo_clock_n <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // on-die termination
  // ---------------------------------------------------------------
  // while enabled, data termination changes only on k-bar, so it drops half a cycle
  // before the drivers turn on and returns half a cycle after
  wire logic dq_busy;

  assign dq_busy = s2_read | rd_stat.oe;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      term_dq_on  <= `DBS_TERM_RST;
      term_ctl_on <= `DBS_TERM_RST;
    end else if (clk_en) begin
      term_ctl_on <= te_s;
      if (!te_s) begin
        term_dq_on <= 1'b0;
      end else if (kb_rise) begin
        term_dq_on <= ~dq_busy;
      end
    end
  end

  // pll enable follows the active-low disable pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_on <= `DBS_PLL_RST;
    end else if (clk_en) begin
      pll_on <= pll_dis_n_s;
    end
  end

  // ---------------------------------------------------------------
  // output impedance calibration
  // ---------------------------------------------------------------
  // a higher code switches in more binary-weighted legs, which lowers
  // the impedance; the analog comparator says which way to go
  logic [CW-1:0] cal_cnt;
  wire  logic    cal_tick;
  wire  logic    step_up;
  wire  logic    step_down;

  assign cal_tick  = (cal_cnt == CAL_LAST);
  assign step_up   = above_s & ~below_s & (drive_code != IMP_MAX);
  assign step_down = below_s & ~above_s & (drive_code != '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_cnt <= '0;
    end else if (clk_en) begin
      cal_cnt <= cal_tick ? '0 : cal_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_code <= IMP_RST;
    end else if (clk_en && cal_tick) begin
      if (step_up) begin
        drive_code <= drive_code + IMP_W'(1);
      end else if (step_down) begin
        drive_code <= drive_code - IMP_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/dbs_defs.svh
// Purpose: constants of the burst-of-two ddr sram interface
// Assumes: included by the package and by the interface module
// Notes:   definitions only
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

// widths
`define DBS_BYTE_W       9
`define DBS_DATA_W       18
`define DBS_ADDR_W       8
`define DBS_ADDR_MAX     24
`define DBS_IMP_W        4

// byte write masks and field positions
`define DBS_BEAT0_LO     0
`define DBS_NO_MASK      1'b0

// flag field offsets inside the synchronised pin vector
`define DBS_F_IMP_BELOW  0
`define DBS_F_IMP_ABOVE  1
`define DBS_F_PLL_DIS_N  2
`define DBS_F_TERM_EN    3
`define DBS_F_RW         4
`define DBS_F_LOAD_N     5
`define DBS_F_KB         6
`define DBS_F_K          7
`define DBS_F_COUNT      8

// timing counts in clk cycles
`define DBS_CAL_PERIOD   1024

// reset values
`define DBS_ECHO_RST     1'b0
`define DBS_TERM_RST     1'b0
`define DBS_PLL_RST      1'b0

`endif

// File: rtl/dbs_pkg.sv
// Purpose: types of the burst-of-two ddr sram interface
// Assumes: dbs_defs.svh holds the numeric constants
// Notes:   nothing here is imported; users write dbs_pkg::name
`include "dbs_defs.svh"

package dbs_pkg;

  // command captured on a k rising edge
  typedef enum logic [1:0] {
    DBS_NOP,
    DBS_READ,
    DBS_WRITE
  } dbs_cmd_t;

  // one slot of the command pipeline
  typedef struct packed {
    dbs_cmd_t                   cmd;
    logic [`DBS_ADDR_MAX-1:0]   addr;
  } dbs_slot_t;

  // status of the read output stage
  typedef struct packed {
    logic oe;
    logic valid;
  } dbs_rdstat_t;

endpackage

// File: testbench/dbs_sram_props.sv
// Purpose: port checker of dbs_sram_if
// Assumes: pins pass two flops inside the design, as mirrored here
// Notes:   bound to the design after the module
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_sram_props #(
  parameter int DATA_W     = `DBS_DATA_W,
  parameter int ADDR_W     = `DBS_ADDR_W,
  parameter int IMP_W      = `DBS_IMP_W,
  parameter int CAL_PERIOD = `DBS_CAL_PERIOD
) (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        clk_en,
  input wire logic                        k_in,
  input wire logic                        k_bar_in,
  input wire logic                        load_n,
  input wire logic                        rw_sel,
  input wire logic [ADDR_W-1:0]           sync_addr_in,
  input wire logic [DATA_W/`DBS_BYTE_W-1:0] byte_write_enable_n,
  input wire logic [DATA_W-1:0]           dq_in,
  input wire logic [DATA_W-1:0]           dq_out,
  input wire logic                        dq_oe,
  input wire logic                        echo_clock,
  input wire logic                        echo_clock_n,
  input wire logic                        read_valid_out,
  input wire logic                        termination_enable,
  input wire logic                        term_dq_on,
  input wire logic                        term_ctl_on,
  input wire logic                        pll_disable_n,
  input wire logic                        pll_on,
  input wire logic                        imp_above,
  input wire logic                        imp_below,
  input wire logic [IMP_W-1:0]            drive_code
);
  logic             k1, k2, k3, l1, l2, r1, r2, p1, p2;
  logic [IMP_W-1:0] pc;
  logic [IMP_W-1:0] dif;
  logic [15:0]      cnt;
  wire              krise = k2 & ~k3;
  wire              chg = drive_code != pc;
  assign dif = drive_code - pc;
  // p2 holds the read that must answer at the coming k rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {k1, k2, k3, l1, l2, r1, r2, p1, p2} <= '0;
      pc <= {1'b1, {(IMP_W-1){1'b0}}};
      cnt <= '0;
    end else if (clk_en) begin
      {k1, k2, k3} <= {k_in, k1, k2};
      {l1, l2, r1, r2} <= {load_n, l1, rw_sel, r1};
      if (krise) begin
        p1 <= ~l2 & r2;
        p2 <= p1;
      end
      pc <= drive_code;
      cnt <= chg ? '0 : cnt + 16'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_valid_with_oe: assert property (read_valid_out == dq_oe)
    else $error("read valid differs from output enable");
  a_read_latency: assert property (krise && p2 |-> ##1 dq_oe)
    else $error("read data not driven two k cycles on");
  a_idle_no_drive: assert property (krise && !p2 |-> ##1 !dq_oe)
    else $error("drivers on without a read");
  a_oe_stands: assert property
    ($changed(dq_oe) |-> $past(krise) || $past(krise, 2))
    else $error("output enable moved away from a k rise");
  a_drive_no_term: assert property (dq_oe |-> !term_dq_on)
    else $error("data termination on while driving");
  a_term_on: assert property (termination_enable [*5] |-> term_ctl_on)
    else $error("control termination off while enabled");
  a_term_off: assert property
    (!termination_enable [*5] |-> !term_ctl_on && !term_dq_on)
    else $error("termination on while disabled");
  a_pll_off: assert property (!pll_disable_n [*5] |-> !pll_on)
    else $error("pll on while disabled");
  a_code_step: assert property (chg |-> dif == 1 || dif == '1)
    else $error("drive code moved more than one step");
  a_code_period: assert property (chg |-> cnt >= CAL_PERIOD - 2)
    else $error("drive code moved too soon");
  c_read: cover property (krise && p2);
  c_code: cover property (chg);
  c_term: cover property ($fell(term_dq_on));
endmodule
bind dbs_sram_if dbs_sram_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
  .IMP_W(IMP_W), .CAL_PERIOD(CAL_PERIOD)) u_props (.*);
`default_nettype wire

// File: testbench/dbs_host_model.sv
// Purpose: memory controller model driving k, k-bar, commands and data
// Assumes: one slot call is one k period of 12 clk cycles
// Notes:   pins change 3 clk away from every k or k-bar rise
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_host_model #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 8,
  parameter int NB     = DATA_W / `DBS_BYTE_W
) (
  input  wire logic              clk,
  input  wire logic              dq_oe,
  input  wire logic [DATA_W-1:0] dq_out,
  output var  logic              k_in,
  output var  logic              k_bar_in,
  output var  logic              load_n,
  output var  logic              rw_sel,
  output var  logic [ADDR_W-1:0] sync_addr_in,
  output var  logic [NB-1:0]     byte_write_enable_n,
  output wire logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0]   hd;
  logic [2*DATA_W-1:0] pw;
  logic [2*NB-1:0]     pb;
  logic                pv;
  // released host lines show the inverse of their last value
  assign dq_in = dq_oe ? dq_out : hd;
  initial begin
    {k_in, k_bar_in, load_n, rw_sel} = 4'h7;
    sync_addr_in = '0;
    byte_write_enable_n = '1;
    hd = '0;
    pw = '0;
    pb = '1;
    pv = 1'b0;
  end
  task automatic half();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // data of a write-select slot is offered in the next slot, loaded or not
  task automatic slot(input logic ld, input logic rw,
      input logic [ADDR_W-1:0] a, input logic [2*DATA_W-1:0] wd,
      input logic [2*NB-1:0] wb);
    load_n = ld;
    rw_sel = rw;
    sync_addr_in = a;
    hd = pv ? pw[DATA_W-1:0] : ~hd;
    byte_write_enable_n = pv ? pb[NB-1:0] : '1;
    half();
    {k_in, k_bar_in} = 2'b10;
    half();
    hd = pv ? pw[2*DATA_W-1:DATA_W] : ~hd;
    byte_write_enable_n = pv ? pb[2*NB-1:NB] : '1;
    half();
    {k_in, k_bar_in} = 2'b01;
    half();
    pv = ~rw;
    pw = wd;
    pb = wb;
  endtask
endmodule
`default_nettype wire

// File: testbench/dbs_sram_if_bench.sv
// Purpose: self-checking bench of dbs_sram_if
// Assumes: 40 MHz clk, k period of 12 clk made by the host model
// Notes:   read words are collected from the pins and compared in order
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_sram_if_bench;
  localparam int DW = 18;
  localparam int AW = 8;
  localparam int CP = 8;
  localparam int NB = DW / `DBS_BYTE_W;
  typedef struct packed {
    logic [AW-1:0]   a;
    logic [2*DW-1:0] d;
    logic [2*NB-1:0] b;
    logic [2*DW-1:0] e;
  } dbs_row_t;
  dbs_row_t rows [4] = '{
    '{8'h10, 36'h123456789, 4'h0, 36'h123456789},
    '{8'h10, 36'hfffffffff, 4'h6, 36'hffb4567ff},
    '{8'hff, 36'h0aaaa5555, 4'h0, 36'h0aaaa5555},
    '{8'hff, 36'h000000000, 4'hf, 36'h0aaaa5555}};
  logic            clk, sys_rst, te, pdn, above, below, le, ce;
  wire             k, kb, ld, rw, oe, ec, ecn, rv, tdq, tctl, pll;
  wire  [AW-1:0]   a;
  wire  [NB-1:0]   bwn;
  wire  [DW-1:0]   dqi, dqo;
  wire  [3:0]      code;
  logic [DW-1:0]   b0;
  logic [2*DW-1:0] got [$];
  int              errors, check_count;
  dbs_sram_if #(.DATA_W(DW), .ADDR_W(AW), .IMP_W(4), .CAL_PERIOD(CP)) DUT (
    .clk(clk), .sys_rst(sys_rst), .clk_en(ce), .k_in(k), .k_bar_in(kb),
    .load_n(ld), .rw_sel(rw), .sync_addr_in(a), .byte_write_enable_n(bwn),
    .dq_in(dqi), .dq_out(dqo), .dq_oe(oe), .echo_clock(ec),
    .echo_clock_n(ecn), .read_valid_out(rv), .termination_enable(te),
    .term_dq_on(tdq), .term_ctl_on(tctl), .pll_disable_n(pdn),
    .pll_on(pll), .imp_above(above), .imp_below(below), .drive_code(code));
  dbs_host_model #(.DATA_W(DW), .ADDR_W(AW)) HOST (
    .clk(clk), .dq_oe(oe), .dq_out(dqo), .k_in(k), .k_bar_in(kb),
    .load_n(ld), .rw_sel(rw), .sync_addr_in(a), .byte_write_enable_n(bwn),
    .dq_in(dqi));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // beat0 while echo is high, beat1 once it has fallen; falling edge
  // so the outputs have settled
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (ec === 1'b1) b0 <= dqo;
      else if (le === 1'b1) got.push_back({dqo, b0});
    end
    le <= ec;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [35:0] exp,
      input logic [35:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) HOST.slot(1'b1, 1'b1, '0, '0, '1);
  endtask
  task automatic rd(input logic [AW-1:0] ad);
    HOST.slot(1'b0, 1'b1, ad, '0, '1);
  endtask
  task automatic take(input logic [2*DW-1:0] e);
    check("read word", e, got.size() > 0 ? got.pop_front() : 'x);
  endtask
  task automatic complete_run();
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(25 * 6000);
    errors++;
    complete_run();
  end
  initial begin
    {ce, sys_rst, te, pdn, above, below} = 6'b111100;
    errors = 0;
    check_count = 0;
    tick(20);
    check("reset outputs", 36'h048, 36'({oe, rv, ec, ecn, tctl, pll, code}));
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      HOST.slot(1'b0, 1'b0, rows[i].a, rows[i].d, rows[i].b);
      idle(1);
      rd(rows[i].a);
      idle(3);
      take(rows[i].e);
    end
    rd(8'h10);
    rd(8'hff);
    idle(3);
    take(36'hffb4567ff);
    take(36'h0aaaa5555);
    HOST.slot(1'b1, 1'b0, 8'hff, 36'h123123123, 4'h0);
    idle(1);
    rd(8'hff);
    idle(3);
    take(36'h0aaaa5555);
    HOST.slot(1'b0, 1'b0, 8'h20, 36'h3c3c3c3c3, 4'h0);
    rd(8'h10);
    idle(2);
    rd(8'h20);
    idle(3);
    take(36'hffb4567ff);
    take(36'h3c3c3c3c3);
    check("termination idle", 36'h3, 36'({tdq, tctl}));
    te = 1'b0;
    tick(6);
    check("termination off", 36'h0, 36'({tdq, tctl}));
    te = 1'b1;
    pdn = 1'b0;
    tick(6);
    check("pll off", 36'h0, 36'(pll));
    pdn = 1'b1;
    tick(6);
    check("pll on", 36'h1, 36'(pll));
    above = 1'b1;
    tick(CP * 10);
    check("drive code up", 36'hf, 36'(code));
    {above, below} = 2'b01;
    tick(CP * 20);
    check("drive code down", 36'h0, 36'(code));
    {ce, above, below} = 3'b010;
    tick(CP * 4);
    check("frozen drive code", 36'h0, 36'(code));
    {ce, above} = 2'b10;
    sys_rst = 1'b1;
    tick(2);
    check("reset outputs", 36'h048, 36'({oe, rv, ec, ecn, tctl, pll, code}));
    sys_rst = 1'b0;
    idle(1);
    rd(8'h10);
    idle(3);
    take(36'hffb4567ff);
    complete_run();
  end
endmodule
`default_nettype wire
